// File: fuse_cfg.svh
`ifndef FUSE_CFG_SVH
`define FUSE_CFG_SVH

// ------------------------------------------------------------
// Identification and calibration addresses
// ------------------------------------------------------------
`define IDENT_ADDR_0       2'h0
`define IDENT_ADDR_1       2'h1
`define IDENT_ADDR_2       2'h2
`define TRIM_ADDR          2'h0

// ------------------------------------------------------------
// Fuse byte selectors
// ------------------------------------------------------------
`define SEL_LOW            2'h0
`define SEL_HIGH           2'h1
`define SEL_EXT            2'h2

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define EXT_SELF_WRITE_BIT 0
`define HI_RESET_OFF_BIT   7
`define HI_DEBUG_ON_BIT    6
`define HI_SERIAL_BIT      5
`define HI_WDOG_BIT        4
`define HI_EEKEEP_BIT      3
`define LO_DIV_BIT         7
`define LO_CLKOUT_BIT      6

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define EXT_FUSE_DEFAULT   8'hff
`define HIGH_FUSE_DEFAULT  8'hdf
`define LOW_FUSE_DEFAULT   8'h62

// ------------------------------------------------------------
// Memory geometry
// ------------------------------------------------------------
`define FLASH_WORD_MSB     5
`define FLASH_PC_MSB       12
`define EE_BYTE_MSB        1
`define EE_ADDR_MSB        8

`endif

// File: fuse_pkg.sv
package fuse_pkg;
  typedef enum logic [2:0] {
    MODE_POWERUP = 3'h1,
    MODE_NORMAL  = 3'h2,
    MODE_PROG    = 3'h4
  } latch_mode_t;
  typedef logic [7:0] fuse_byte_t;
endpackage : fuse_pkg

// File: sync2.sv
`timescale 1ns/1ns
module sync2 (
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic sys_rst_in,
  // Level
  input  wire logic d_in,
  output logic      q_out
);
  logic meta_r;
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      meta_r <= 1'b0;
      q_out  <= 1'b0;
    end else begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end
endmodule : sync2

// File: addr_split.sv
`timescale 1ns/1ns
`include "fuse_cfg.svh"
module addr_split (
  // Program counter
  input  wire logic [`FLASH_PC_MSB:0]                 pc_in,
  // Nonvolatile data address
  input  wire logic [`EE_ADDR_MSB:0]                  ee_addr_in,
  // Flash split
  output logic [`FLASH_WORD_MSB:0]                    word_in_page_index_out,
  output logic [`FLASH_PC_MSB-`FLASH_WORD_MSB-1:0]    page_number_index_out,
  // Data memory split
  output logic [`EE_BYTE_MSB:0]                       ee_byte_out,
  output logic [`EE_ADDR_MSB-`EE_BYTE_MSB-1:0]        ee_page_out
);
  assign word_in_page_index_out = pc_in[`FLASH_WORD_MSB:0];
  assign page_number_index_out  = pc_in[`FLASH_PC_MSB:`FLASH_WORD_MSB+1];
  assign ee_byte_out = ee_addr_in[`EE_BYTE_MSB:0];
  assign ee_page_out = ee_addr_in[`EE_ADDR_MSB:`EE_BYTE_MSB+1];
endmodule : addr_split

// File: fuse_config_latch.sv
`timescale 1ns/1ns
`include "fuse_cfg.svh"
// Contract
// - Self-write allowed only with fuse programmed
// - Fuse bits read zero when programmed
// - Extended byte: bit0 self-write, others one
// - High byte field layout and defaults
// - Serial-allow fuse locked in serial mode
// - Defaults pick 8 MHz RC, longest start
// - Clock output fuse drives clock pin
// - Capture on programming entry, hold until next entry
// - Data keep fuse acts immediately
// - Capture fuses at power-up normal mode
// - Three identification bytes, always readable
// - Trim byte copied to trim register at reset
// - Flash pages of 64 words
// - Data memory 128 pages of 4 bytes
// - Chip erase keeps fuses, keeps data if set
module fuse_config_latch #(
  // Arbitrary identification values
  parameter logic [7:0] IDENT_0 = 8'h5a,
  parameter logic [7:0] IDENT_1 = 8'h01,
  parameter logic [7:0] IDENT_2 = 8'h02,
  parameter logic [7:0] TRIM_DEFAULT = 8'h80
) (
  // Clock and reset
  input  wire logic                        ref_clk_in,
  input  wire logic                        sys_rst_in,
  // Mode pins
  input  wire logic                        prog_mode_pin_in,
  input  wire logic                        serial_mode_in,
  // Programmer fuse access
  input  wire logic                        fuse_wr_in,
  input  wire logic [1:0]                  fuse_sel_in,
  input  wire fuse_pkg::fuse_byte_t        fuse_wdata_in,
  output fuse_pkg::fuse_byte_t             fuse_rdata_out,
  // Identification access
  input  wire logic [1:0]                  ident_addr_in,
  input  wire logic                        ident_hi_in,
  output logic [7:0]                       ident_rdata_out,
  // Chip erase
  input  wire logic                        chip_erase_in,
  output logic                             erase_flash_out,
  output logic                             erase_eeprom_out,
  // Self-program request
  input  wire logic                        self_write_req_in,
  output logic                             self_write_go_out,
  // System clock, sampled slow copy to the pin
  input  wire logic                        sys_clk_in,
  output logic                             clock_out_pin_out,
  output logic                             clock_out_pin_oe_out,
  // Configuration outputs
  output logic                             ext_reset_off_out,
  output logic                             onchip_debug_on_out,
  output logic                             watchdog_force_on_out,
  output logic [2:0]                       brownout_level_out,
  output logic                             clock_divide_out,
  output logic [1:0]                       startup_time_out,
  output logic [3:0]                       clock_source_out,
  output logic [7:0]                       rc_trim_register_out,
  // Address split
  input  wire logic [`FLASH_PC_MSB:0]      pc_in,
  input  wire logic [`EE_ADDR_MSB:0]       ee_addr_in,
  output logic [`FLASH_WORD_MSB:0]         word_in_page_index_out,
  output logic [6:0]                       page_number_index_out,
  output logic [`EE_BYTE_MSB:0]            ee_byte_out,
  output logic [6:0]                       ee_page_out,
  // Status
  output logic                             in_prog_out
);
  import fuse_pkg::*;

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic prog_s;
  logic clk_s;
  sync2 u_sync_prog (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .d_in       (prog_mode_pin_in),
    .q_out      (prog_s)
  );
  // Clock echo is sampled, so it is a slow copy only
  sync2 u_sync_clk (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .d_in       (sys_clk_in),
    .q_out      (clk_s)
  );

  addr_split u_split (
    .pc_in                  (pc_in),
    .ee_addr_in             (ee_addr_in),
    .word_in_page_index_out (word_in_page_index_out),
    .page_number_index_out  (page_number_index_out),
    .ee_byte_out            (ee_byte_out),
    .ee_page_out            (ee_page_out)
  );

  // ------------------------------------------------------------
  // Mode sequencing
  // ------------------------------------------------------------
  latch_mode_t mode_r;
  latch_mode_t mode_nxt;
  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      MODE_POWERUP: mode_nxt = prog_s ? MODE_PROG : MODE_NORMAL;
      MODE_NORMAL: begin
        if (prog_s) begin
          mode_nxt = MODE_PROG;
        end
      end
      MODE_PROG: begin
        if (!prog_s) begin
          mode_nxt = MODE_NORMAL;
        end
      end
      default: mode_nxt = MODE_POWERUP;
    endcase
  end
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      mode_r <= MODE_POWERUP;
    end else begin
      mode_r <= mode_nxt;
    end
  end
  logic capture;
  assign capture = (mode_r == MODE_POWERUP) ||
                   (mode_r == MODE_NORMAL && mode_nxt == MODE_PROG);
  assign in_prog_out = (mode_r == MODE_PROG);

  // ------------------------------------------------------------
  // Fuse storage
  // ------------------------------------------------------------
  fuse_byte_t ext_fuse_r;
  fuse_byte_t high_fuse_r;
  fuse_byte_t low_fuse_r;
  logic       wr_ok;
  assign wr_ok = fuse_wr_in && in_prog_out;
  // Extended byte, unused bits stay one
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      ext_fuse_r <= `EXT_FUSE_DEFAULT;
    end else if (wr_ok && fuse_sel_in == `SEL_EXT) begin
      ext_fuse_r <= {7'h7f, fuse_wdata_in[`EXT_SELF_WRITE_BIT]};
    end
  end
  ext_unused_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    ext_fuse_r[7:1] == 7'h7f)
    else $error("unused extended bits not one");
  // Serial-allow bit protected in serial mode
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      high_fuse_r <= `HIGH_FUSE_DEFAULT;
    end else if (wr_ok && fuse_sel_in == `SEL_HIGH) begin
      high_fuse_r <= fuse_wdata_in;
      if (serial_mode_in) begin
        high_fuse_r[`HI_SERIAL_BIT] <= high_fuse_r[`HI_SERIAL_BIT];
      end
    end
  end
  serial_protect_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    $past(serial_mode_in) |-> $stable(high_fuse_r[5]))
    else $error("serial allow fuse changed in serial mode");
  // Defaults: RC 8 MHz, longest start
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      low_fuse_r <= `LOW_FUSE_DEFAULT;
    end else if (wr_ok && fuse_sel_in == `SEL_LOW) begin
      low_fuse_r <= fuse_wdata_in;
    end
  end
  write_refused_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !in_prog_out |=> $stable(low_fuse_r) && $stable(high_fuse_r) && $stable(ext_fuse_r))
    else $error("fuse written outside programming");
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      fuse_rdata_out <= 8'hff;
    end else begin
      unique case (fuse_sel_in)
        `SEL_LOW:  fuse_rdata_out <= low_fuse_r;
        `SEL_HIGH: fuse_rdata_out <= high_fuse_r;
        `SEL_EXT:  fuse_rdata_out <= ext_fuse_r;
        default:   fuse_rdata_out <= 8'hff;
      endcase
    end
  end
  erase_fuses_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    chip_erase_in && !fuse_wr_in |=> $stable(high_fuse_r))
    else $error("erase changed fuses");
  erase_low_fuse_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    chip_erase_in && !fuse_wr_in |=> $stable(low_fuse_r) && $stable(ext_fuse_r))
    else $error("erase changed low or extended fuses");

  // ------------------------------------------------------------
  // Latched copies
  // ------------------------------------------------------------
  fuse_byte_t ext_lat_r;
  fuse_byte_t high_lat_r;
  fuse_byte_t low_lat_r;
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      ext_lat_r  <= `EXT_FUSE_DEFAULT;
      high_lat_r <= `HIGH_FUSE_DEFAULT;
      low_lat_r  <= `LOW_FUSE_DEFAULT;
    end else if (capture) begin
      ext_lat_r  <= ext_fuse_r;
      high_lat_r <= high_fuse_r;
      low_lat_r  <= low_fuse_r;
    end
  end
  latch_hold_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    in_prog_out && $past(in_prog_out) |-> $stable(low_lat_r))
    else $error("latched fuses moved during programming");
  capture_entry_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    in_prog_out && !$past(in_prog_out) |-> low_lat_r == $past(low_fuse_r) &&
      high_lat_r == $past(high_fuse_r) && ext_lat_r == $past(ext_fuse_r))
    else $error("fuses not captured on programming entry");
  powerup_capture_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    $past(mode_r) == MODE_POWERUP |-> low_lat_r == $past(low_fuse_r) &&
      high_lat_r == $past(high_fuse_r))
    else $error("fuses not captured at power-up");
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      ext_reset_off_out     <= 1'b0;
      onchip_debug_on_out   <= 1'b0;
      watchdog_force_on_out <= 1'b0;
      brownout_level_out    <= 3'h7;
      clock_divide_out      <= 1'b1;
      startup_time_out      <= 2'h2;
      clock_source_out      <= 4'h2;
    end else begin
      ext_reset_off_out     <= ~high_lat_r[`HI_RESET_OFF_BIT];
      onchip_debug_on_out   <= ~high_lat_r[`HI_DEBUG_ON_BIT];
      watchdog_force_on_out <= ~high_lat_r[`HI_WDOG_BIT];
      brownout_level_out    <= high_lat_r[2:0];
      clock_divide_out      <= ~low_lat_r[`LO_DIV_BIT];
      startup_time_out      <= low_lat_r[5:4];
      clock_source_out      <= low_lat_r[3:0];
    end
  end
  cfg_steady_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !$past(capture) && !$past(capture, 2) |-> $stable(clock_source_out))
    else $error("configuration moved without capture");

  // ------------------------------------------------------------
  // Self-programming gate
  // ------------------------------------------------------------
  // Self-write only with fuse at zero
  assign self_write_go_out = self_write_req_in && !ext_lat_r[`EXT_SELF_WRITE_BIT];
  self_write_gate_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    ext_lat_r[0] |-> !self_write_go_out)
    else $error("self write passed while disabled");
  self_write_open_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    self_write_req_in && !ext_lat_r[`EXT_SELF_WRITE_BIT] |-> self_write_go_out)
    else $error("self write blocked while enabled");

  // ------------------------------------------------------------
  // Chip erase
  // ------------------------------------------------------------
  logic keep_now;
  // Keep fuse read live, not latched
  assign keep_now = !high_fuse_r[`HI_EEKEEP_BIT];
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      erase_flash_out  <= 1'b0;
      erase_eeprom_out <= 1'b0;
    end else begin
      erase_flash_out  <= chip_erase_in && in_prog_out;
      // Data kept when keep fuse set
      erase_eeprom_out <= chip_erase_in && in_prog_out && !keep_now;
    end
  end
  eeprom_keep_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    chip_erase_in && keep_now |=> !erase_eeprom_out)
    else $error("data erased while keep fuse set");
  erase_idle_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !in_prog_out |=> !erase_flash_out && !erase_eeprom_out)
    else $error("erase issued outside programming");

  // ------------------------------------------------------------
  // Clock output
  // ------------------------------------------------------------
  // Drive clock pin when fuse programmed
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      clock_out_pin_out    <= 1'b0;
      clock_out_pin_oe_out <= 1'b0;
    end else begin
      clock_out_pin_out    <= clk_s;
      clock_out_pin_oe_out <= ~low_lat_r[`LO_CLKOUT_BIT];
    end
  end
  clkout_enable_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    ##1 clock_out_pin_oe_out == !$past(low_lat_r[6]))
    else $error("clock pin enable wrong");

  // ------------------------------------------------------------
  // Identification and trim
  // ------------------------------------------------------------
  // Ident bytes readable regardless of lock
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      ident_rdata_out <= 8'h00;
    end else if (ident_hi_in) begin
      ident_rdata_out <= (ident_addr_in == `TRIM_ADDR) ? TRIM_DEFAULT : 8'h00;
    end else begin
      unique case (ident_addr_in)
        `IDENT_ADDR_0: ident_rdata_out <= IDENT_0;
        `IDENT_ADDR_1: ident_rdata_out <= IDENT_1;
        `IDENT_ADDR_2: ident_rdata_out <= IDENT_2;
        default:       ident_rdata_out <= 8'h00;
      endcase
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      rc_trim_register_out <= TRIM_DEFAULT;
    end
  end
  trim_byte_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    ident_hi_in && ident_addr_in == `TRIM_ADDR |=> ident_rdata_out == TRIM_DEFAULT)
    else $error("trim byte not returned");
endmodule : fuse_config_latch

// File: prog_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Programmer model on the fuse access side
// ----------------------------------------
module prog_model (
  // Clock and status
  input  wire logic           ref_clk_in,
  input  wire logic           in_prog_in,
  // Programmer lines
  output logic                prog_pin_out,
  output logic                serial_out,
  output logic                wr_out,
  output logic [1:0]          sel_out,
  output fuse_pkg::fuse_byte_t wdata_out,
  output logic                erase_out
);
  import fuse_pkg::*;
  initial begin
    prog_pin_out = 1'b0;
    serial_out   = 1'b0;
    wr_out       = 1'b0;
    sel_out      = 2'h3;
    wdata_out    = 8'h00;
    erase_out    = 1'b0;
  end
  task automatic step();
    @(posedge ref_clk_in);
    #1;
  endtask : step
  // Mode pin is a level; wait bounded for the synced view to follow
  task automatic set_prog(input logic on);
    prog_pin_out = on;
    for (int i = 0; i < 10 && in_prog_in !== on; i++) step();
    step();
  endtask : set_prog
  // Data is inverted once released so a stale byte never looks valid
  task automatic write_fuse(input logic [1:0] sel, input fuse_byte_t data);
    step();
    wr_out    = 1'b1;
    sel_out   = sel;
    wdata_out = data;
    step();
    wr_out    = 1'b0;
    sel_out   = 2'h3;
    wdata_out = ~data;
  endtask : write_fuse
  task automatic erase();
    step();
    erase_out = 1'b1;
    step();
    erase_out = 1'b0;
  endtask : erase
  task automatic select(input logic [1:0] sel);
    step();
    sel_out = sel;
    step();
    step();
  endtask : select
endmodule : prog_model

// File: fuse_config_latch_test.sv
`timescale 1ns/1ns
module fuse_config_latch_test;
  import fuse_pkg::*;
  // Arbitrary identification and trim values
  localparam logic [7:0] ID0 = 8'h3c;
  localparam logic [7:0] ID1 = 8'h11;
  localparam logic [7:0] ID2 = 8'h22;
  localparam logic [7:0] TRM = 8'h4b;
  logic ref_clk_in, sys_rst_in, pm, sm, wr, ce, er_f, er_e, swr, swg, sck, cko, coe;
  logic rst_off, dbg, wdg, cdiv, ihi, inp;
  logic [1:0] sel, iad, sut, eb;
  logic [2:0] bod;
  logic [3:0] src;
  logic [5:0] wip;
  logic [6:0] pgn, eep;
  logic [7:0] ird, trim;
  logic [12:0] pc;
  logic [8:0] eea;
  fuse_byte_t wd, frd;
  int fail_count, n_tests;
  // ----------------------------------------
  // Clock, instances
  // ----------------------------------------
  initial begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end
  // Slow unrelated system clock for the output pin path
  initial begin
    sck = 1'b0;
    // Offset keeps its edges away from the sampling edge
    #7;
    forever #130 sck = ~sck;
  end
  prog_model prog_model_inst (.ref_clk_in(ref_clk_in), .in_prog_in(inp), .prog_pin_out(pm),
    .serial_out(sm), .wr_out(wr), .sel_out(sel), .wdata_out(wd), .erase_out(ce));
  fuse_config_latch #(.IDENT_0(ID0), .IDENT_1(ID1), .IDENT_2(ID2), .TRIM_DEFAULT(TRM))
  fuse_config_latch_inst (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .prog_mode_pin_in(pm), .serial_mode_in(sm), .fuse_wr_in(wr), .fuse_sel_in(sel),
    .fuse_wdata_in(wd), .fuse_rdata_out(frd), .ident_addr_in(iad), .ident_hi_in(ihi),
    .ident_rdata_out(ird), .chip_erase_in(ce), .erase_flash_out(er_f),
    .erase_eeprom_out(er_e), .self_write_req_in(swr), .self_write_go_out(swg),
    .sys_clk_in(sck), .clock_out_pin_out(cko), .clock_out_pin_oe_out(coe),
    .ext_reset_off_out(rst_off), .onchip_debug_on_out(dbg), .watchdog_force_on_out(wdg),
    .brownout_level_out(bod), .clock_divide_out(cdiv), .startup_time_out(sut),
    .clock_source_out(src), .rc_trim_register_out(trim), .pc_in(pc), .ee_addr_in(eea),
    .word_in_page_index_out(wip), .page_number_index_out(pgn), .ee_byte_out(eb),
    .ee_page_out(eep), .in_prog_out(inp));
  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic step();
    @(posedge ref_clk_in);
    #1;
  endtask : step
  task automatic rd_fuse(input logic [1:0] s, input logic [7:0] exp);
    prog_model_inst.select(s);
    chk("fuse byte", {8'h00, exp}, {8'h00, frd});
  endtask : rd_fuse
  // Packs every latched configuration output into one compare word
  task automatic chk_cfg(input logic [14:0] exp);
    repeat (4) step();
    chk("config", {1'b0, exp}, {1'b0, rst_off, dbg, wdg, bod, cdiv, sut, src, coe, swg});
  endtask : chk_cfg
  task automatic report_and_stop();
    if (fail_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_defaults();
    rd_fuse(2'h0, 8'h62);
    rd_fuse(2'h1, 8'hdf);
    rd_fuse(2'h2, 8'hff);
    chk_cfg({3'b000, 3'h7, 1'b1, 2'h2, 4'h2, 1'b0, 1'b0});
    chk("trim", {8'h00, TRM}, {8'h00, trim});
  endtask : t_defaults
  task automatic t_ident();
    logic [7:0] exp [4] = '{ID0, ID1, ID2, TRM};
    for (int i = 0; i < 4; i++) begin
      ihi = (i == 3);
      iad = (i == 3) ? 2'h0 : 2'(i);
      repeat (2) step();
      chk("ident", {8'h00, exp[i]}, {8'h00, ird});
    end
  endtask : t_ident
  task automatic t_split();
    pc  = 13'h1abc;
    eea = 9'h1ed;
    #1;
    chk("flash split", {3'h0, 7'h6a, 6'h3c}, {3'h0, pgn, wip});
    chk("ee split", {7'h00, 7'h7b, 2'h1}, {7'h00, eep, eb});
  endtask : t_split
  // Writes and erase are refused outside programming mode
  task automatic t_refused();
    prog_model_inst.write_fuse(2'h0, 8'h00);
    chk("erase idle", 16'h0, {14'h0, er_f, er_e});
    prog_model_inst.erase();
    chk("erase idle", 16'h0, {14'h0, er_f, er_e});
    rd_fuse(2'h0, 8'h62);
  endtask : t_refused
  task automatic t_prog_write();
    prog_model_inst.set_prog(1'b1);
    chk("in prog", 16'h1, {15'h0, inp});
    prog_model_inst.erase();
    chk("erase all", 16'h3, {14'h0, er_f, er_e});
    prog_model_inst.write_fuse(2'h0, 8'ha1);
    prog_model_inst.write_fuse(2'h1, 8'h44);
    prog_model_inst.write_fuse(2'h2, 8'h00);
    rd_fuse(2'h2, 8'hfe);
    prog_model_inst.serial_out = 1'b1;
    prog_model_inst.write_fuse(2'h1, 8'h64);
    prog_model_inst.serial_out = 1'b0;
    rd_fuse(2'h1, 8'h44);
    prog_model_inst.erase();
    chk("erase keep", 16'h2, {14'h0, er_f, er_e});
    rd_fuse(2'h0, 8'ha1);
    chk_cfg({3'b000, 3'h7, 1'b1, 2'h2, 4'h2, 1'b0, 1'b0});
    prog_model_inst.set_prog(1'b0);
    chk_cfg({3'b000, 3'h7, 1'b1, 2'h2, 4'h2, 1'b0, 1'b0});
  endtask : t_prog_write
  // Pin copy lags the slow clock by two sampling edges
  task automatic t_recapture();
    logic [2:0] h;
    prog_model_inst.set_prog(1'b1);
    chk_cfg({3'b101, 3'h4, 1'b0, 2'h2, 4'h1, 1'b1, 1'b1});
    swr = 1'b0;
    #1;
    chk("self write", 16'h0, {15'h0, swg});
    h = 3'h0;
    for (int i = 0; i < 16; i++) begin
      step();
      h = {h[1:0], sck};
      if (i >= 2) begin
        chk("clock out", {15'h0, h[2]}, {15'h0, cko});
      end
    end
  endtask : t_recapture
  // Mid-run reset with the mode pin high passes through normal mode into programming
  task automatic t_reset();
    prog_model_inst.prog_pin_out = 1'b1;
    sys_rst_in = 1'b1;
    repeat (8) step();
    sys_rst_in = 1'b0;
    chk_cfg({3'b000, 3'h7, 1'b1, 2'h2, 4'h2, 1'b0, 1'b0});
    chk("in prog", 16'h1, {15'h0, inp});
    chk("trim", {8'h00, TRM}, {8'h00, trim});
    rd_fuse(2'h1, 8'hdf);
  endtask : t_reset
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    fail_count = 0;
    n_tests    = 0;
    sys_rst_in = 1'b1;
    iad = 2'h0;
    ihi = 1'b0;
    swr = 1'b1;
    pc  = 13'h0000;
    eea = 9'h000;
    repeat (8) step();
    sys_rst_in = 1'b0;
    t_defaults();
    t_ident();
    t_split();
    t_refused();
    t_prog_write();
    t_recapture();
    t_reset();
    report_and_stop();
  end
  initial begin
    #(40 * 3000);
    fail_count++;
    report_and_stop();
  end
endmodule : fuse_config_latch_test
